// ### cal_pkg.sv
// Shared constants and types for the calibration self-test sequencer
package cal_pkg;

  // ----------------------------------------------------------------
  // Sequence constants
  // ----------------------------------------------------------------
  localparam int          NUM_CONST    = 14;
  localparam logic [3:0]  TOP_INDEX    = 4'hD;
  localparam logic [3:0]  LAST_INDEX   = 4'h0;
  localparam logic [3:0]  STEP         = 4'h1;
  localparam logic [15:0] DUMMY_EXPECT = 16'h2710;  // 10.000 in thousandths
  localparam logic [23:0] DONE_DIGITS  = 24'h888888;
  localparam logic [5:0]  DONE_POINTS  = 6'h3F;
  localparam logic [19:0] INT_PAD      = 20'h00000;
  localparam logic [7:0]  VALUE_PAD    = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ      = 50;
  localparam int          SHOW_TIME_US = 50;
  localparam int          SHOW_CYCLES  = SHOW_TIME_US * CLK_MHZ;
  localparam logic [11:0] SHOW_COUNT   = 12'(SHOW_CYCLES);
  localparam logic [11:0] CNT_STEP     = 12'h001;

  // Constants measured per sample interval, by sample rate code
  localparam logic [3:0] CAL_PER_SAMPLE [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

  // ----------------------------------------------------------------
  // Limit windows (signed result)
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_LO  = 16'hFC00;
  localparam logic [15:0] OFF_HI  = 16'h0400;
  localparam logic [15:0] GAIN_LO = 16'h2000;
  localparam logic [15:0] GAIN_HI = 16'h3000;
  localparam logic [15:0] LIMIT_LO [NUM_CONST] = '{GAIN_LO, OFF_LO, OFF_LO, OFF_LO, OFF_LO,
    GAIN_LO, OFF_LO, OFF_LO, OFF_LO, OFF_LO, GAIN_LO, OFF_LO, GAIN_LO, OFF_LO};
  localparam logic [15:0] LIMIT_HI [NUM_CONST] = '{GAIN_HI, OFF_HI, OFF_HI, OFF_HI, OFF_HI,
    GAIN_HI, OFF_HI, OFF_HI, OFF_HI, OFF_HI, GAIN_HI, OFF_HI, GAIN_HI, OFF_HI};

  // ----------------------------------------------------------------
  // Measurement path setting
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {GAIN_X1, GAIN_X2, GAIN_X10, GAIN_X20, GAIN_X100} gain_t;
  typedef enum logic [2:0] {IN_NONE, IN_REF_PM, IN_GND, IN_REF10, IN_ATT10, IN_ATT100,
                            IN_DIV10} input_t;
  typedef enum logic {TOP_GND, TOP_REF} top_t;
  typedef struct packed {
    gain_t  gain;
    input_t src;
    top_t   top;
  } path_t;

  // ----------------------------------------------------------------
  // Display word
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DISP_BLANK, DISP_INT, DISP_VALUE, DISP_DONE} disp_kind_t;
  typedef struct packed {
    disp_kind_t  kind;
    logic        sign;
    logic [5:0]  points;
    logic [23:0] digits;
  } disp_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_MEAS  = 8'h02,
    ST_WAIT  = 8'h04,
    ST_HALT  = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DWAIT = 8'h20,
    ST_DHALT = 8'h40,
    ST_SHOW  = 8'h80
  } state_t;

endpackage : cal_pkg

// ### cal_point_check.sv
// Path selection and limit check for one calibration constant index
`timescale 1ns/1ps
`default_nettype none
module cal_point_check
  import cal_pkg::*;
(
  // Constant under test
  input  wire logic [3:0]  index,
  input  wire logic [15:0] result,
  // Path and verdict
  output path_t            path,
  output logic             pass
);

  logic inRange;
  assign inRange = (index <= TOP_INDEX);

  // --------------------------------------------------------------
  // Path per constant
  // --------------------------------------------------------------
  always_comb begin
    path = '{gain: GAIN_X1, src: IN_NONE, top: TOP_GND};
    case (index)
      4'hD: path = '{gain: GAIN_X1,   src: IN_NONE,   top: TOP_GND}; // RQ15
      4'hC: path = '{gain: GAIN_X1,   src: IN_REF_PM, top: TOP_GND}; // RQ15
      4'hB: path = '{gain: GAIN_X1,   src: IN_GND,    top: TOP_GND}; // RQ16
      4'hA: path = '{gain: GAIN_X1,   src: IN_REF10,  top: TOP_GND}; // RQ16
      4'h9: path = '{gain: GAIN_X20,  src: IN_GND,    top: TOP_GND}; // RQ17
      4'h8: path = '{gain: GAIN_X2,   src: IN_GND,    top: TOP_GND}; // RQ17
      4'h7: path = '{gain: GAIN_X1,   src: IN_ATT10,  top: TOP_GND}; // RQ18
      4'h6: path = '{gain: GAIN_X1,   src: IN_ATT100, top: TOP_GND}; // RQ18
      4'h5: path = '{gain: GAIN_X10,  src: IN_ATT10,  top: TOP_REF}; // RQ19
      4'h4: path = '{gain: GAIN_X10,  src: IN_ATT10,  top: TOP_GND}; // RQ19
      4'h3: path = '{gain: GAIN_X100, src: IN_GND,    top: TOP_GND}; // RQ20
      4'h2: path = '{gain: GAIN_X10,  src: IN_GND,    top: TOP_GND}; // RQ20
      4'h1: path = '{gain: GAIN_X10,  src: IN_DIV10,  top: TOP_GND}; // RQ21
      4'h0: path = '{gain: GAIN_X10,  src: IN_DIV10,  top: TOP_REF}; // RQ21
      default: path = '{gain: GAIN_X1, src: IN_NONE, top: TOP_GND};
    endcase
  end

  // --------------------------------------------------------------
  // Limit window
  // --------------------------------------------------------------
  logic signed [15:0] lo;
  logic signed [15:0] hi;
  assign lo   = inRange ? signed'(LIMIT_LO[index]) : 16'sh0000;
  assign hi   = inRange ? signed'(LIMIT_HI[index]) : 16'sh0000;
  assign pass = inRange && (signed'(result) >= lo) && (signed'(result) <= hi); // RQ23

endmodule : cal_point_check
`default_nettype wire

// ### cal_self_test_seq.sv
// Calibration constant sequencer with self-test loop and auto-cal stepping
// Notes on behaviour
// RQ1 - Fourteen constants, indexed thirteen down to zero
// RQ2 - Auto-cal remeasures constants between normal samples
// RQ3 - Test key starts pass at constant 13
// RQ4 - In-limit constant advances to next lower automatically
// RQ5 - Out-of-limit constant halts, shows its index
// RQ6 - Test key after halt resumes next constant
// RQ7 - Dummy calculation expects 10, blank when right
// RQ8 - Wrong dummy result shown, halt until test
// RQ9 - Full pass shows plus and lit eights
// RQ10 - Finished pass restarts automatically, indefinitely
// RQ11 - Other function key leaves self-test loop
// RQ12 - Bus gets nothing when constants fail
// RQ13 - Bus gets wrong dummy result alone
// RQ14 - Bus gets 10 on full pass
// RQ15 - Constant 13 offset, 12 reference ratio
// RQ16 - Constants 11,10 unity gain, ground/reference
// RQ17 - Constants 9,8 gain twenty/two, grounded
// RQ18 - Constants 7,6 unity through ten/hundred attenuator
// RQ19 - Constants 5,4 gain ten, 10:1 attenuator
// RQ20 - Constants 3,2 gain hundred/ten, grounded
// RQ21 - Constants 1,0 gain ten via divider
// RQ22 - Auto-cal count per sample follows rate
// RQ23 - Index decrements, fixed limits, latch failing index
`timescale 1ns/1ps
`default_nettype none
module cal_self_test_seq
  import cal_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Front panel and mode pins
  input  wire logic        testKey,
  input  wire logic        fnKey,
  input  wire logic        autoCalMode,
  input  wire logic        busRemote,
  // Sample timing
  input  wire logic        sampleTick,
  input  wire logic [1:0]  sampleRate,
  // Measurement path
  output logic             measStart,
  output path_t            measPath,
  output logic [3:0]       measIndex,
  input  wire logic        measDone,
  input  wire logic [15:0] measResult,
  // Dummy calculation
  output logic             calcStart,
  input  wire logic        calcDone,
  input  wire logic [15:0] calcResult,
  // Display, bus and status
  output disp_t            display,
  output logic             busValid,
  output logic [15:0]      busValue,
  output logic             selfTest,
  output logic             busy,
  // Constant readback
  input  wire logic [3:0]  constSel,
  output logic [15:0]      constData
);

  // --------------------------------------------------------------
  // Pin synchronisers and edges
  // --------------------------------------------------------------
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [3:0] syncPrev;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA    <= 4'h0;
      syncB    <= 4'h0;
      syncPrev <= 4'h0;
    end else begin
      syncA    <= {busRemote, autoCalMode, fnKey, testKey};
      syncB    <= syncA;
      syncPrev <= syncB;
    end
  end

  logic testPress;
  logic fnPress;
  logic autoOn;
  logic busOn;
  assign testPress = syncB[0] && !syncPrev[0];
  assign fnPress   = syncB[1] && !syncPrev[1];
  assign autoOn    = syncB[2];
  assign busOn     = syncB[3];

  // --------------------------------------------------------------
  // State and registers
  // --------------------------------------------------------------
  state_t      state;
  logic [3:0]  index;
  logic [3:0]  budget;
  logic [11:0] showCnt;
  logic        failSeen;
  logic        dummyBad;
  logic [15:0] constMem [NUM_CONST];

  path_t pointPath;
  logic  pointPass;
  cal_point_check u_check (
    .index  (index),
    .result (measResult),
    .path   (pointPath),
    .pass   (pointPass)
  );

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  logic measGot;
  logic calcGot;
  logic calcOk;
  logic atLast;
  logic lastAuto;
  logic showEnd;
  logic autoKick;
  logic exitReq;
  logic [3:0] lowerIdx;
  logic [3:0] wrapIdx;
  assign measGot  = (state == ST_WAIT) && measDone;
  assign calcGot  = (state == ST_DWAIT) && calcDone;
  assign calcOk   = (calcResult == DUMMY_EXPECT);
  assign atLast   = (index == LAST_INDEX);
  assign lastAuto = (budget <= STEP);
  assign showEnd  = (showCnt >= SHOW_COUNT - CNT_STEP);
  assign autoKick = (state == ST_IDLE) && !selfTest && autoOn && sampleTick && !testPress;
  assign exitReq  = selfTest && fnPress;
  assign lowerIdx = index - STEP; // RQ23
  assign wrapIdx  = atLast ? TOP_INDEX : lowerIdx; // RQ1

  assign measStart = (state == ST_MEAS);
  assign calcStart = (state == ST_DUMMY);
  assign measPath  = pointPath;
  assign measIndex = index;
  assign busy      = (state != ST_IDLE);

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  state_t      next_state;
  logic [3:0]  next_index;
  logic [3:0]  next_budget;
  logic        next_selfTest;
  logic        next_failSeen;
  logic        next_dummyBad;
  always_comb begin
    next_state    = state;
    next_index    = index;
    next_budget   = budget;
    next_selfTest = selfTest;
    next_failSeen = failSeen;
    next_dummyBad = dummyBad;
    if (exitReq) begin
      next_state    = ST_IDLE; // RQ11
      next_selfTest = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (testPress) begin
            next_state    = ST_MEAS; // RQ3
            next_index    = TOP_INDEX;
            next_selfTest = 1'b1;
            next_failSeen = 1'b0;
            next_dummyBad = 1'b0;
          end else if (autoKick) begin
            next_state  = ST_MEAS; // RQ2
            next_budget = CAL_PER_SAMPLE[sampleRate]; // RQ22
          end
        end
        ST_MEAS: next_state = ST_WAIT;
        ST_WAIT: begin
          if (measDone && selfTest) begin
            if (!pointPass) begin
              next_state    = ST_HALT; // RQ5
              next_failSeen = 1'b1;
            end else if (atLast) begin
              next_state = ST_DUMMY;
            end else begin
              next_state = ST_MEAS; // RQ4
              next_index = lowerIdx;
            end
          end else if (measDone) begin
            next_index  = wrapIdx; // RQ2
            next_budget = budget - STEP;
            next_state  = lastAuto ? ST_IDLE : ST_MEAS; // RQ22
          end
        end
        ST_HALT: begin
          if (testPress) begin
            next_state = atLast ? ST_DUMMY : ST_MEAS; // RQ6
            next_index = atLast ? index : lowerIdx;
          end
        end
        ST_DUMMY: next_state = ST_DWAIT;
        ST_DWAIT: begin
          if (calcDone) begin
            next_state    = calcOk ? ST_SHOW : ST_DHALT; // RQ7
            next_dummyBad = !calcOk; // RQ8
          end
        end
        ST_DHALT: begin
          if (testPress) begin
            next_state = ST_SHOW; // RQ8
          end
        end
        ST_SHOW: begin
          if (showEnd) begin
            next_state    = ST_MEAS; // RQ10
            next_index    = TOP_INDEX;
            next_failSeen = 1'b0;
            next_dummyBad = 1'b0;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Display and bus words
  // --------------------------------------------------------------
  logic  showDone;
  logic  failNow;
  disp_t next_display;
  assign showDone = (state == ST_SHOW) && !failSeen && !dummyBad;
  assign failNow  = measGot && selfTest && !pointPass;
  always_comb begin
    next_display = display;
    if (exitReq || testPress) begin
      next_display = '{kind: DISP_BLANK, sign: 1'b0, points: 6'h00, digits: 24'h000000};
    end
    if (!exitReq) begin
      if (failNow) begin
        next_display = '{kind: DISP_INT, sign: 1'b0, points: 6'h00,
                         digits: {INT_PAD, index}}; // RQ5
      end else if (calcGot && calcOk) begin
        next_display = '{kind: DISP_BLANK, sign: 1'b0, points: 6'h00,
                         digits: 24'h000000}; // RQ7
      end else if (calcGot) begin
        next_display = '{kind: DISP_VALUE, sign: 1'b0, points: 6'h00,
                         digits: {VALUE_PAD, calcResult}}; // RQ8
      end else if (showDone) begin
        next_display = '{kind: DISP_DONE, sign: 1'b1, points: DONE_POINTS,
                         digits: DONE_DIGITS}; // RQ9
      end
    end
  end

  logic busSend;
  assign busSend = calcGot && busOn && !failSeen && !exitReq; // RQ12

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state    <= ST_IDLE;
      index    <= TOP_INDEX;
      budget   <= 4'h0;
      selfTest <= 1'b0;
      failSeen <= 1'b0;
      dummyBad <= 1'b0;
      display  <= '{kind: DISP_BLANK, sign: 1'b0, points: 6'h00, digits: 24'h000000};
    end else begin
      state    <= next_state;
      index    <= next_index;
      budget   <= next_budget;
      selfTest <= next_selfTest;
      failSeen <= next_failSeen;
      dummyBad <= next_dummyBad;
      display  <= next_display;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busValid <= 1'b0;
      busValue <= 16'h0000;
      showCnt  <= 12'h000;
    end else begin
      busValid <= busSend;
      if (busSend) begin
        busValue <= calcOk ? DUMMY_EXPECT : calcResult; // RQ13 RQ14
      end
      showCnt <= (state == ST_SHOW) ? showCnt + CNT_STEP : 12'h000;
    end
  end

  // Constant store, one word per index
  always_ff @(posedge ref_clk) begin
    if (measGot && (index <= TOP_INDEX)) begin
      constMem[index] <= measResult; // RQ1
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      constData <= 16'h0000;
    end else begin
      constData <= (constSel <= TOP_INDEX) ? constMem[constSel] : 16'h0000;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  start_at_top_a: assert property ( // RQ3
    state == ST_IDLE && testPress && !fnPress |=> state == ST_MEAS && index == TOP_INDEX)
    else $error("self-test did not start at constant 13");

  step_down_a: assert property ( // RQ4
    measGot && selfTest && pointPass && !atLast && !fnPress
    |=> state == ST_MEAS ##1 state == ST_WAIT && index == $past(index, 2) - STEP)
    else $error("passing constant did not advance to the next lower one");

  fail_halt_a: assert property ( // RQ5
    failNow && !fnPress |=> state == ST_HALT && display.kind == DISP_INT
                           && display.digits == {INT_PAD, $past(index)})
    else $error("failing constant did not halt with its index shown");

  resume_next_a: assert property ( // RQ6
    state == ST_HALT && testPress && !fnPress && !atLast
    |=> state == ST_MEAS && index == $past(index) - STEP)
    else $error("test key after halt did not resume with next constant");

  dummy_ok_a: assert property ( // RQ7
    calcGot && calcOk && !fnPress |=> state == ST_SHOW && display.kind == DISP_BLANK)
    else $error("correct dummy result not accepted");

  dummy_bad_a: assert property ( // RQ8
    calcGot && !calcOk && !fnPress
    |=> state == ST_DHALT && display.digits[15:0] == $past(calcResult))
    else $error("wrong dummy result not shown and held");

  done_show_a: assert property ( // RQ9
    showDone && !fnPress |=> display.kind == DISP_DONE && display.points == DONE_POINTS)
    else $error("completion pattern missing");

  loop_again_a: assert property ( // RQ10
    state == ST_SHOW && showEnd && !fnPress |=> state == ST_MEAS && index == TOP_INDEX)
    else $error("self-test did not restart");

  exit_loop_a: assert property ( // RQ11
    exitReq |=> (state == ST_IDLE && !selfTest) [*2])
    else $error("function key did not leave self-test");

  bus_silent_a: assert property ( // RQ12
    failSeen |-> !busSend)
    else $error("bus output despite failing constant");

  bus_pass_a: assert property ( // RQ14
    busSend && calcOk |=> busValid && busValue == DUMMY_EXPECT)
    else $error("bus did not report 10 on pass");

  auto_count_a: assert property ( // RQ22
    autoKick && !fnPress |=> state == ST_MEAS && budget == CAL_PER_SAMPLE[$past(sampleRate)])
    else $error("auto-cal budget not loaded from rate");

  gain_route_a: assert property ( // RQ16
    measStart && index == 4'hA |-> measPath.gain == GAIN_X1 && measPath.src == IN_REF10)
    else $error("constant 10 path wrong");

  full_pass_c:  cover property (showDone ##1 display.kind == DISP_DONE);
  halt_seen_c:  cover property (state == ST_HALT ##[1:50] state == ST_MEAS);
  dummy_bad_c:  cover property (state == ST_DHALT);
  auto_run_c:   cover property (autoKick ##[1:50] state == ST_IDLE);

endmodule : cal_self_test_seq
`default_nettype wire

// ### meas_path_model.sv
// Model of the analog measurement path and the dummy calculation unit
`timescale 1ns/1ps
`default_nettype none
module meas_path_model
  import cal_pkg::*;
(
  // Clock and scenario control
  input  wire logic        ref_clk,
  input  wire logic [13:0] failMask,
  input  wire logic [7:0]  lag,
  input  wire logic [15:0] dummyValue,
  // Sequencer side
  input  wire logic        measStart,
  input  wire logic [3:0]  measIndex,
  input  wire logic        calcStart,
  output logic             measDone,
  output logic [15:0]      measResult,
  output logic             calcDone,
  output logic [15:0]      calcResult
);
  logic [7:0] mCnt;
  logic [7:0] cCnt;
  logic       mPend;
  logic       cPend;
  logic [3:0] mIdx;
  logic       isGain;

  assign isGain = (mIdx == 4'h0) || (mIdx == 4'h5) || (mIdx == 4'hA) || (mIdx == 4'hC);

  initial begin
    {measDone, calcDone, mPend, cPend} = 4'h0;
    measResult = 16'h0000;
    calcResult = 16'h0000;
  end

  // One job at a time, answer no earlier than the cycle after the start
  always @(negedge ref_clk) begin
    measDone   <= 1'b0;
    calcDone   <= 1'b0;
    measResult <= ~measResult;
    calcResult <= ~calcResult;
    if (measStart) begin
      mPend <= 1'b1;
      mCnt  <= lag;
      mIdx  <= measIndex;
    end else if (mPend) begin
      mCnt <= mCnt - 8'h01;
      if (mCnt == 8'h00) begin
        mPend      <= 1'b0;
        measDone   <= 1'b1;
        measResult <= failMask[mIdx] ? 16'h7FFF : (isGain ? 16'h2800 : 16'h0010);
      end
    end
    if (calcStart) begin
      cPend <= 1'b1;
      cCnt  <= lag;
    end else if (cPend) begin
      cCnt <= cCnt - 8'h01;
      if (cCnt == 8'h00) begin
        cPend      <= 1'b0;
        calcDone   <= 1'b1;
        calcResult <= dummyValue;
      end
    end
  end
endmodule : meas_path_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the calibration self-test sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cal_pkg::*;
;
  logic        ref_clk, rst, testKey, fnKey, autoCalMode, busRemote;
  logic        sampleTick, measStart, measDone, calcStart, calcDone;
  logic        busValid, selfTest, busy;
  logic [1:0]  sampleRate;
  path_t       measPath;
  logic [3:0]  measIndex, constSel;
  logic [15:0] measResult, calcResult, busValue, constData, dummyValue;
  disp_t       display;
  logic [13:0] failMask, w;
  logic [7:0]  lag;
  logic [4:0]  note;
  logic [4:0]  expMeas[$];
  logic [15:0] expBus[$];
  int          n_mismatch, num_checks, seed;

  cal_self_test_seq DUT (.ref_clk(ref_clk), .rst(rst), .testKey(testKey), .fnKey(fnKey),
    .autoCalMode(autoCalMode), .busRemote(busRemote), .sampleTick(sampleTick),
    .sampleRate(sampleRate), .measStart(measStart), .measPath(measPath),
    .measIndex(measIndex), .measDone(measDone), .measResult(measResult),
    .calcStart(calcStart), .calcDone(calcDone), .calcResult(calcResult),
    .display(display), .busValid(busValid), .busValue(busValue), .selfTest(selfTest),
    .busy(busy), .constSel(constSel), .constData(constData));

  meas_path_model path_model (.ref_clk(ref_clk), .failMask(failMask), .lag(lag),
    .dummyValue(dummyValue), .measStart(measStart), .measIndex(measIndex),
    .calcStart(calcStart), .measDone(measDone), .measResult(measResult),
    .calcDone(calcDone), .calcResult(calcResult));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic press(input bit fn);
    fnKey = fn;
    testKey = !fn;
    cyc(4);
    fnKey = 1'b0;
    testKey = 1'b0;
    cyc(2);
  endtask : press

  task automatic waitKind(input disp_kind_t k);
    for (int i = 0; i < 2000 && display.kind !== k; i++) cyc(1);
    check(display.kind, k);
  endtask : waitKind

  task automatic waitEmpty();
    for (int i = 0; i < 3000 && expMeas.size() != 0; i++) cyc(1);
    check(expMeas.size(), 0);
  endtask : waitEmpty

  task automatic pushPass();
    lag = 8'($random(seed)) & 8'h03;
    for (int i = 13; i >= 0; i--) expMeas.push_back(5'(i));
  endtask : pushPass

  task automatic exitLoop();
    lag = 8'h40;
    press(1'b1);
    check(selfTest, 1'b0);
    check(display.kind, DISP_BLANK);
    cyc(70);
  endtask : exitLoop

  // Expected path: compare mask, then gain, source, top
  function automatic logic [13:0] want(input logic [3:0] i);
    case (i)
      4'hD: want = {7'h0E, GAIN_X1, IN_NONE, TOP_GND};
      4'hC: want = {7'h0E, GAIN_X1, IN_REF_PM, TOP_GND};
      4'hB: want = {7'h7E, GAIN_X1, IN_GND, TOP_GND};
      4'hA: want = {7'h7E, GAIN_X1, IN_REF10, TOP_GND};
      4'h9: want = {7'h7E, GAIN_X20, IN_GND, TOP_GND};
      4'h8: want = {7'h7E, GAIN_X2, IN_GND, TOP_GND};
      4'h7: want = {7'h7F, GAIN_X1, IN_ATT10, TOP_GND};
      4'h6: want = {7'h7F, GAIN_X1, IN_ATT100, TOP_GND};
      4'h5: want = {7'h7F, GAIN_X10, IN_ATT10, TOP_REF};
      4'h4: want = {7'h7F, GAIN_X10, IN_ATT10, TOP_GND};
      4'h3: want = {7'h7E, GAIN_X100, IN_GND, TOP_GND};
      4'h2: want = {7'h7E, GAIN_X10, IN_GND, TOP_GND};
      4'h1: want = {7'h7F, GAIN_X10, IN_DIV10, TOP_GND};
      default: want = {7'h7F, GAIN_X10, IN_DIV10, TOP_REF};
    endcase
  endfunction : want

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (measStart) begin
      if (expMeas.size() == 0) begin
        check(1, 0);
      end else begin
        note = expMeas.pop_front();
        w = want(measIndex);
        if (!note[4]) check(measIndex, note[3:0]);
        check(measPath & w[13:7], w[6:0] & w[13:7]);
      end
    end
    if (busValid) begin
      if (expBus.size() == 0) check(1, 0);
      else check(busValue, expBus.pop_front());
    end
  end

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    #(20 * 60000);
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h00005EE5;
    {rst, testKey, fnKey, autoCalMode, busRemote, sampleTick} = 6'h20;
    sampleRate = 2'h0;
    constSel = 4'h0;
    failMask = 14'h0000;
    lag = 8'h00;
    dummyValue = DUMMY_EXPECT;
    cyc(6);
    rst = 1'b0;
    check(measIndex, 4'hD);
    busRemote = 1'b1;
    pushPass();
    expBus.push_back(DUMMY_EXPECT);
    press(1'b0);
    check(selfTest, 1'b1);
    waitKind(DISP_DONE);
    check({display.sign, display.points, display.digits}, {1'b1, 6'h3F, 24'h888888});
    check(expBus.size(), 0);
    lag = 8'h40;
    expMeas.push_back(5'h0D);
    waitEmpty();
    exitLoop();
    for (int i = 0; i < 15; i++) begin
      constSel = 4'(i);
      cyc(2);
      check(constData, (i > 13) ? 16'h0000 : ((i == 0 || i == 5 || i == 10 || i == 12)
        ? 16'h2800 : 16'h0010));
    end
    $display("clean pass test done");
    failMask = 14'h0200;
    pushPass();
    press(1'b0);
    waitKind(DISP_INT);
    check(display.digits[3:0], 4'h9);
    cyc(20);
    check({display.kind, 5'(expMeas.size())}, {DISP_INT, 5'h09});
    failMask = 14'h0000;
    press(1'b0);
    waitEmpty();
    cyc(40);
    check(display.kind, DISP_BLANK);
    exitLoop();
    $display("failing constant test done");
    dummyValue = 16'h2706;
    pushPass();
    expBus.push_back(16'h2706);
    press(1'b0);
    waitKind(DISP_VALUE);
    cyc(20);
    check({display.kind, display.digits[15:0]}, {DISP_VALUE, 16'h2706});
    press(1'b0);
    check(display.kind, DISP_BLANK);
    check(expBus.size(), 0);
    exitLoop();
    $display("dummy failure test done");
    busRemote = 1'b0;
    autoCalMode = 1'b1;
    cyc(4);
    for (int r = 0; r < 4; r++) begin
      sampleRate = 2'(r);
      lag = 8'($random(seed)) & 8'h03;
      repeat (CAL_PER_SAMPLE[r]) expMeas.push_back(5'h10);
      sampleTick = 1'b1;
      cyc(1);
      sampleTick = 1'b0;
      waitEmpty();
      cyc(30);
      check(busy, 1'b0);
    end
    $display("auto-cal test done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
